// file: hdl/hlpt_pkg.sv
// constants, register map and carrier types for the limit period timer
package hlpt_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned CNT_W  = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODE    = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD  = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_COUNT   = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN  = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 5'h14;

  // field positions
  localparam int unsigned CTRL_ON_BIT    = 7;
  localparam int unsigned CTRL_PRE_LSB   = 4;
  localparam int unsigned CTRL_POST_LSB  = 0;
  localparam int unsigned IRQ_EN_BIT     = 0;
  localparam int unsigned STATUS_IRQ_BIT = 0;

  // mode codes
  localparam logic [4:0] M_SW_GATE     = 5'h00;
  localparam logic [4:0] M_GATE_HI     = 5'h01;
  localparam logic [4:0] M_GATE_LO     = 5'h02;
  localparam logic [4:0] M_EDGE_ANY    = 5'h03;
  localparam logic [4:0] M_EDGE_RISE   = 5'h04;
  localparam logic [4:0] M_EDGE_FALL   = 5'h05;
  localparam logic [4:0] M_LVL_LO      = 5'h06;
  localparam logic [4:0] M_LVL_HI      = 5'h07;
  localparam logic [4:0] M_OS_SW       = 5'h08;
  localparam logic [4:0] M_OS_RISE     = 5'h09;
  localparam logic [4:0] M_OS_FALL     = 5'h0A;
  localparam logic [4:0] M_OS_ANY      = 5'h0B;
  localparam logic [4:0] M_OS_HLT_RISE = 5'h0C;
  localparam logic [4:0] M_OS_HLT_FALL = 5'h0D;
  localparam logic [4:0] M_OS_LVL_LO   = 5'h0E;
  localparam logic [4:0] M_OS_LVL_HI   = 5'h0F;

  // timing: synchroniser stages in clk_in cycles, restart delay in timer ticks
  localparam int unsigned SYNC_STAGES   = 2;
  localparam logic [1:0]  RESTART_TICKS = 2'h2;

  typedef struct packed {
    logic             on;
    logic [2:0]       prescale_select;
    logic [3:0]       postscale_select;
    logic [4:0]       mode;
    logic [CNT_W-1:0] period_value;
  } hlpt_cfg_t;

  localparam hlpt_cfg_t CFG_RESET = '{
    on: 1'b0, prescale_select: 3'h0, postscale_select: 4'h0,
    mode: 5'h00, period_value: 8'hFF};

endpackage

// file: hdl/hlpt_sync.sv
// level synchroniser chain for the run bit and the trigger input
`timescale 1ns/1ps
module hlpt_sync #(
  parameter int unsigned STAGES = 2
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic d_in,
  output logic      q_out
);

  logic [STAGES-1:0] chain;

  initial begin
    if (STAGES < 2) begin
      $error("hlpt_sync needs at least two stages");
    end
  end

  // only the last stage is visible; earlier stages may be metastable
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], d_in};
    end
  end

  assign q_out = chain[STAGES-1];

endmodule

// file: hdl/hlpt_timer.sv
// eight-bit period timer with hardware limit modes and avalon registers
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module hlpt_timer (
  input  wire logic                          clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic [hlpt_pkg::ADDR_W-1:0]   address_in,
  input  wire logic                          read_in,
  input  wire logic                          write_in,
  input  wire logic [hlpt_pkg::DATA_W-1:0]   writedata_in,
  output logic      [hlpt_pkg::DATA_W-1:0]   readdata_out,
  output logic                               waitrequest_out,
  input  wire logic                          ext_reset_input_in,
  input  wire logic                          debug_freeze_in,
  output logic      [hlpt_pkg::CNT_W-1:0]    count_value_out,
  output logic                               period_match_out,
  output logic                               postscaled_out,
  output logic                               irq_out
);

  // decoding shared by several terms
  function automatic logic is_oneshot(input logic [4:0] m);
    return (m >= hlpt_pkg::M_OS_SW) && (m <= hlpt_pkg::M_OS_LVL_HI);
  endfunction

  function automatic logic pick_edge(input logic [4:0] m,
                                     input logic rise, input logic fall);
    unique case (m)
      hlpt_pkg::M_EDGE_ANY, hlpt_pkg::M_OS_ANY: return rise | fall;
      hlpt_pkg::M_EDGE_RISE, hlpt_pkg::M_OS_RISE,
      hlpt_pkg::M_OS_HLT_RISE, hlpt_pkg::M_OS_LVL_LO: return rise;
      hlpt_pkg::M_EDGE_FALL, hlpt_pkg::M_OS_FALL,
      hlpt_pkg::M_OS_HLT_FALL, hlpt_pkg::M_OS_LVL_HI: return fall;
      default: return 1'b0;
    endcase
  endfunction

  hlpt_pkg::hlpt_cfg_t          cfg;
  logic                         irq_en;
  logic                         irq_flag;
  logic [hlpt_pkg::CNT_W-1:0]   count;
  logic [6:0]                   pre_cnt;
  logic                         ers_frz;
  logic                         ers_prev;
  logic [1:0]                   ers_d;
  logic [1:0]                   dly;
  logic                         started;
  logic                         done;
  logic [3:0]                   ps_cnt;

  // avalon slave: one wait state per access
  wire req      = read_in | write_in;
  wire wr_fire  = write_in & ~waitrequest_out;
  wire wr_ctrl  = wr_fire && address_in == hlpt_pkg::ADDR_CTRL;
  wire wr_mode  = wr_fire && address_in == hlpt_pkg::ADDR_MODE;
  wire wr_per   = wr_fire && address_in == hlpt_pkg::ADDR_PERIOD;
  wire wr_irqen = wr_fire && address_in == hlpt_pkg::ADDR_IRQ_EN;
  wire wr_stat  = wr_fire && address_in == hlpt_pkg::ADDR_STATUS;

  logic [hlpt_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (address_in)
      hlpt_pkg::ADDR_CTRL:   rd_mux[7:0] = {cfg.on, cfg.prescale_select,
                                            cfg.postscale_select};
      hlpt_pkg::ADDR_MODE:   rd_mux[4:0] = cfg.mode;
      hlpt_pkg::ADDR_PERIOD: rd_mux[7:0] = cfg.period_value;
      hlpt_pkg::ADDR_COUNT:  rd_mux[7:0] = count;
      hlpt_pkg::ADDR_IRQ_EN: rd_mux[hlpt_pkg::IRQ_EN_BIT] = irq_en;
      hlpt_pkg::ADDR_STATUS: rd_mux[hlpt_pkg::STATUS_IRQ_BIT] = irq_flag;
      default:               rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      waitrequest_out <= 1'b1;
      readdata_out    <= '0;
    end else begin
      waitrequest_out <= ~(req & waitrequest_out);
      if (req & waitrequest_out) begin
        readdata_out <= rd_mux;
      end
    end
  end

  // synchronisers and trigger conditioning
  logic on_s;
  logic ers_s;

  hlpt_sync #(.STAGES(hlpt_pkg::SYNC_STAGES)) u_on_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (cfg.on),
    .q_out      (on_s)
  );

  hlpt_sync #(.STAGES(hlpt_pkg::SYNC_STAGES)) u_ers_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (ext_reset_input_in),
    .q_out      (ers_s)
  );

  // frozen level keeps edge detectors quiet during debug halt
  wire ers  = debug_freeze_in ? ers_frz : ers_s;
  wire rise = ers & ~ers_prev;
  wire fall = ~ers & ers_prev;

  // prescaler; timer clock is a one-cycle tick of clk_in
  wire [6:0] pre_lim = 7'((8'h01 << cfg.prescale_select) - 8'h01);
  wire       tick    = (pre_cnt == pre_lim);

  // mode decode
  wire [4:0] m        = cfg.mode;
  wire is_sw          = (m == hlpt_pkg::M_SW_GATE);
  wire is_gate_hi     = (m == hlpt_pkg::M_GATE_HI);
  wire is_gate_lo     = (m == hlpt_pkg::M_GATE_LO);
  wire is_edge_hlt    = (m >= hlpt_pkg::M_EDGE_ANY) &&
                        (m <= hlpt_pkg::M_EDGE_FALL);
  wire is_lvl_hlt     = (m == hlpt_pkg::M_LVL_LO) ||
                        (m == hlpt_pkg::M_LVL_HI);
  // delay line parks at the non-reset level so switching on is no reset
  wire [1:0] lvl_idle = {2{m == hlpt_pkg::M_LVL_LO}};
  wire is_os_sw       = (m == hlpt_pkg::M_OS_SW);
  wire is_os_edge     = (m >= hlpt_pkg::M_OS_RISE) &&
                        (m <= hlpt_pkg::M_OS_ANY);
  wire is_os_hlt      = (m == hlpt_pkg::M_OS_HLT_RISE) ||
                        (m == hlpt_pkg::M_OS_HLT_FALL);
  wire is_os_lvl      = (m == hlpt_pkg::M_OS_LVL_LO) ||
                        (m == hlpt_pkg::M_OS_LVL_HI);
  wire oneshot        = is_oneshot(m);
  wire rsvd           = !(is_sw | is_gate_hi | is_gate_lo | is_edge_hlt |
                          is_lvl_hlt | oneshot);
  wire edge_sel       = pick_edge(m, rise, fall);

  // level reset in M_LVL_LO and M_LVL_HI is seen through a two-tick delay line; the one-shot level reset is not
  wire lvl_at_rst     = (m == hlpt_pkg::M_LVL_LO) ? ~ers_d[1] : ers_d[1];
  wire os_at_rst      = (m == hlpt_pkg::M_OS_LVL_LO) ? ~ers : ers;

  wire edge_hlt_rst   = on_s & is_edge_hlt & edge_sel;
  wire os_hlt_rst     = on_s & ~done & is_os_hlt & started & edge_sel;
  wire lvl_rst        = on_s & is_lvl_hlt & lvl_at_rst;
  wire oslvl_rst      = is_os_lvl & os_at_rst;
  wire any_rst        = edge_hlt_rst | os_hlt_rst | lvl_rst | oslvl_rst;
  // edges before the run bit is set are ignored
  wire start_ev       = on_s & ~done & ~started & edge_sel &
                        (is_os_edge | is_os_hlt | (is_os_lvl & ~os_at_rst));

  wire mode_run       = is_sw | is_os_sw | is_edge_hlt |
                        (is_gate_hi & ers) | (is_gate_lo & ~ers) |
                        (is_lvl_hlt & ~lvl_at_rst) |
                        ((is_os_edge | is_os_hlt | is_os_lvl) & started);
  wire cnt_en         = on_s & ~done & (dly == 2'h0) & ~rsvd & mode_run;
  wire match          = cnt_en & (count == cfg.period_value);
  wire os_end         = tick & match & oneshot;

  logic [hlpt_pkg::CNT_W-1:0] next_count;
  always_comb begin
    if (rsvd || any_rst) begin
      next_count = '0;
    end else if (match) begin
      next_count = '0;
    end else if (cnt_en) begin
      next_count = count + 8'h01;
    end else begin
      next_count = count;
    end
  end

  // counter core, advances on timer ticks
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pre_cnt <= '0;
      ers_frz <= 1'b0;
    end else begin
      pre_cnt <= (tick || !on_s) ? 7'h00 : pre_cnt + 7'h01;
      if (!debug_freeze_in) begin
        ers_frz <= ers_s;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      count    <= '0;
      ers_prev <= 1'b0;
      ers_d    <= '0;
      dly      <= '0;
      started  <= 1'b0;
      done     <= 1'b0;
      ps_cnt   <= '0;
    end else if (!on_s) begin
      // count holds, except in a reserved mode or a one-shot level reset, so a paused one-shot resumes where it stopped
      ers_prev <= ers;
      ers_d    <= lvl_idle;
      dly      <= '0;
      started  <= 1'b0;
      done     <= 1'b0;
      ps_cnt   <= '0;
      if (rsvd || oslvl_rst) begin
        count <= '0;
      end
    end else if (tick) begin
      count    <= next_count;
      ers_prev <= ers;
      ers_d    <= {ers_d[0], ers};
      if (edge_hlt_rst || os_hlt_rst) begin
        dly <= hlpt_pkg::RESTART_TICKS;
      end else if (dly != 2'h0) begin
        dly <= dly - 2'h1;
      end
      if (os_end || oslvl_rst) begin
        started <= 1'b0;
      end else if (start_ev) begin
        started <= 1'b1;
      end
      if (os_end) begin
        done <= 1'b1;
      end
      if (match) begin
        ps_cnt <= (ps_cnt == cfg.postscale_select) ? 4'h0 : ps_cnt + 4'h1;
      end
    end
  end

  // registers and event outputs
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cfg              <= hlpt_pkg::CFG_RESET;
      irq_en           <= 1'b0;
      irq_flag         <= 1'b0;
      irq_out          <= 1'b0;
      period_match_out <= 1'b0;
      postscaled_out   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        cfg.on               <= writedata_in[hlpt_pkg::CTRL_ON_BIT];
        cfg.prescale_select  <= writedata_in[hlpt_pkg::CTRL_PRE_LSB +: 3];
        cfg.postscale_select <= writedata_in[hlpt_pkg::CTRL_POST_LSB +: 4];
      end else if (os_end) begin
        cfg.on <= 1'b0;
      end
      if (wr_mode) begin
        cfg.mode <= writedata_in[4:0];
      end
      if (wr_per) begin
        cfg.period_value <= writedata_in[hlpt_pkg::CNT_W-1:0];
      end
      if (wr_irqen) begin
        irq_en <= writedata_in[hlpt_pkg::IRQ_EN_BIT];
      end
      period_match_out <= tick & match;
      postscaled_out   <= tick & match &
                          (ps_cnt == cfg.postscale_select);
      // a new event beats a write-one clear in the same cycle
      if (postscaled_out) begin
        irq_flag <= 1'b1;
      end else if (wr_stat && writedata_in[hlpt_pkg::STATUS_IRQ_BIT]) begin
        irq_flag <= 1'b0;
      end
      irq_out <= irq_flag & irq_en;
    end
  end

  assign count_value_out = count;

  // assertions
  sequence s_edge_reset;
    tick && edge_hlt_rst;
  endsequence

  sequence s_restart_hold;
    (count == '0 && dly == hlpt_pkg::RESTART_TICKS);
  endsequence

  postscale_pulse_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    tick && match && ps_cnt == cfg.postscale_select |=> postscaled_out)
    else $error("postscaled pulse missing");

  irq_gate_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    irq_out |-> $past(irq_en) && $past(irq_flag))
    else $error("interrupt raised while disabled");

  sw_gate_hold_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    is_sw && !on_s |=> $stable(count))
    else $error("software gate count moved while off");

  period_wrap_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    tick && match |=> count == '0)
    else $error("count did not wrap after period match");

  edge_restart_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    s_edge_reset |=> s_restart_hold ##1 (count == '0)[*2])
    else $error("edge reset restart delay wrong");

  level_ignore_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    is_lvl_hlt && !on_s |=> $stable(count))
    else $error("level mode reacted while off");

  level_clear_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    tick && lvl_rst && !rsvd |=> count == '0)
    else $error("level reset did not clear count");

  oneshot_stop_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    os_end && !wr_ctrl |=> !cfg.on && count == '0)
    else $error("one-shot match did not clear run bit");

  reserved_idle_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    rsvd && tick |=> count == '0 && !period_match_out)
    else $error("reserved mode produced activity");

endmodule

// file: test/hlpt_timer_test.sv
// self-checking bench for the limit period timer
`timescale 1ns/1ps
module hlpt_timer_test;
  logic                        clk_in;
  logic                        reset_n_in;
  logic [hlpt_pkg::ADDR_W-1:0] address_in;
  logic                        read_in;
  logic                        write_in;
  logic [31:0]                 writedata_in;
  logic [31:0]                 readdata_out;
  logic                        waitrequest_out;
  logic                        trig;
  logic                        lvl;
  logic                        debug_freeze_in;
  logic [7:0]                  count_value_out;
  logic                        period_match_out;
  logic                        postscaled_out;
  logic                        irq_out;
  int                          n_errors;
  int                          check_count;
  int                          cyc;

  hlpt_timer dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .ext_reset_input_in(trig), .debug_freeze_in(debug_freeze_in),
    .count_value_out(count_value_out), .period_match_out(period_match_out),
    .postscaled_out(postscaled_out), .irq_out(irq_out));

  hlpt_trig_model model (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .level_req_in(lvl), .trig_out(trig));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // generous ceiling; the whole sequence needs about two thousand cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits as long as the slave needs; only the run ceiling ends a hang
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
           output logic [31:0] q);
    address_in   <= a;
    writedata_in <= d;
    write_in     <= w;
    read_in      <= !w;
    do begin
      @(posedge clk_in);
    end while (waitrequest_out !== 1'b0);
    q = readdata_out;
    write_in <= 1'b0;
    read_in  <= 1'b0;
    @(posedge clk_in);
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  task set_trig(input logic v);
    lvl <= v;
    repeat (12) @(posedge clk_in);
  endtask

  task setup(input logic [4:0] m, input logic [7:0] p, input logic t);
    wr(hlpt_pkg::ADDR_CTRL, 32'h0);
    wr(hlpt_pkg::ADDR_MODE, {27'h0, m});
    wr(hlpt_pkg::ADDR_PERIOD, {24'h0, p});
    set_trig(t);
  endtask

  task wait_cnt(input logic [7:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (count_value_out !== v && n < 600);
    check({24'h0, count_value_out}, {24'h0, v});
  endtask

  // count stays frozen over twenty clocks
  task hold_chk;
    logic [7:0] c;
    c = count_value_out;
    repeat (20) @(posedge clk_in);
    check({24'h0, count_value_out}, {24'h0, c});
  endtask

  task watch(input int n, output int z, output int m);
    z = 0;
    m = 0;
    repeat (n) begin
      @(posedge clk_in);
      if (count_value_out === 8'h0) z++;
      if (period_match_out === 1'b1) m++;
    end
  endtask

  task t_regs;
    rd_chk(hlpt_pkg::ADDR_CTRL, 32'h0);
    rd_chk(hlpt_pkg::ADDR_MODE, 32'h0);
    rd_chk(hlpt_pkg::ADDR_PERIOD, 32'hff);
    rd_chk(hlpt_pkg::ADDR_IRQ_EN, 32'h0);
    wr(hlpt_pkg::ADDR_COUNT, 32'h55);
    rd_chk(hlpt_pkg::ADDR_COUNT, 32'h0);
    rd_chk(5'h18, 32'h0);
    $display("registers done");
  endtask

  task t_sw;
    setup(hlpt_pkg::M_SW_GATE, 8'h3, 1'b0);
    wr(hlpt_pkg::ADDR_CTRL, 32'h80);
    wait_cnt(8'h3);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      check({24'h0, count_value_out}, i);
    end
    wr(hlpt_pkg::ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk_in);
    hold_chk();
    $display("software gate done");
  endtask

  task t_post;
    int pt[3] = '{0, 3, 15};
    int n;
    int m;
    setup(hlpt_pkg::M_SW_GATE, 8'h1, 1'b0);
    foreach (pt[k]) begin
      wr(hlpt_pkg::ADDR_CTRL, 32'h0);
      wr(hlpt_pkg::ADDR_CTRL, 32'h80 | pt[k]);
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (postscaled_out !== 1'b1 && n < 200);
      m = 0;
      do begin
        @(posedge clk_in);
        n++;
        if (period_match_out === 1'b1) m++;
      end while (postscaled_out !== 1'b1 && n < 400);
      check(m, pt[k] + 1);
    end
    wr(hlpt_pkg::ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk_in);
    check({31'h0, irq_out}, 32'h0);
    rd_chk(hlpt_pkg::ADDR_STATUS, 32'h1);
    wr(hlpt_pkg::ADDR_IRQ_EN, 32'h1);
    repeat (3) @(posedge clk_in);
    check({31'h0, irq_out}, 32'h1);
    wr(hlpt_pkg::ADDR_STATUS, 32'h1);
    repeat (3) @(posedge clk_in);
    check({31'h0, irq_out}, 32'h0);
    wr(hlpt_pkg::ADDR_IRQ_EN, 32'h0);
    $display("postscaler done");
  endtask

  task t_gate;
    for (int k = 0; k < 2; k++) begin
      setup(k[0] ? hlpt_pkg::M_GATE_LO : hlpt_pkg::M_GATE_HI, 8'hff, k[0]);
      wr(hlpt_pkg::ADDR_CTRL, 32'h80);
      hold_chk();
      set_trig(!k[0]);
      wait_cnt(count_value_out + 8'h8);
    end
    $display("hardware gate done");
  endtask

  task t_edge;
    int z;
    int m;
    for (int md = 3; md < 6; md++) begin
      setup(md[4:0], 8'hff, md == 5);
      wr(hlpt_pkg::ADDR_CTRL, 32'h80);
      wait_cnt(8'h10);
      lvl <= md != 5;
      wait_cnt(8'h0);
      for (int i = 0; i < 3; i++) begin
        @(posedge clk_in);
        check({24'h0, count_value_out}, i == 2);
      end
    end
    // trigger edge while frozen must not reset the count
    setup(hlpt_pkg::M_EDGE_RISE, 8'hff, 1'b0);
    debug_freeze_in <= 1'b1;
    wr(hlpt_pkg::ADDR_CTRL, 32'h80);
    wait_cnt(8'h10);
    lvl <= 1'b1;
    watch(30, z, m);
    check(z, 0);
    debug_freeze_in <= 1'b0;
    $display("edge limit done");
  endtask

  task t_level;
    for (int k = 0; k < 2; k++) begin
      setup(k[0] ? hlpt_pkg::M_LVL_HI : hlpt_pkg::M_LVL_LO, 8'hff, !k[0]);
      wr(hlpt_pkg::ADDR_CTRL, 32'h80);
      wait_cnt(8'h10);
      lvl <= k[0];
      wait_cnt(8'h0);
      hold_chk();
      lvl <= !k[0];
      wait_cnt(8'h4);
    end
    $display("level limit done");
  endtask

  task t_os;
    int z;
    int m;
    setup(hlpt_pkg::M_OS_SW, 8'h20, 1'b0);
    wr(hlpt_pkg::ADDR_CTRL, 32'h80);
    wait_cnt(8'h20);
    @(posedge clk_in);
    check({24'h0, count_value_out}, 32'h0);
    rd_chk(hlpt_pkg::ADDR_CTRL, 32'h0);
    hold_chk();
    wr(hlpt_pkg::ADDR_CTRL, 32'h80);
    wait_cnt(8'h8);
    wr(hlpt_pkg::ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk_in);
    hold_chk();
    wr(hlpt_pkg::ADDR_CTRL, 32'h80);
    watch(10, z, m);
    check(z, 0);
    check(m, 0);
    wait_cnt(8'h20);
    repeat (6) @(posedge clk_in);
    rd_chk(hlpt_pkg::ADDR_CTRL, 32'h0);
    $display("software one-shot done");
  endtask

  task t_eos;
    int z;
    int m;
    logic r;
    for (int md = 9; md < 16; md++) begin
      r = md == 9 || md == 11 || md == 12 || md == 14;
      setup(md[4:0], 8'h10, !r);
      wr(hlpt_pkg::ADDR_CTRL, 32'h80);
      watch(20, z, m);
      check(z, 20);
      lvl <= r;
      wait_cnt(8'h10);
      repeat (6) @(posedge clk_in);
      rd_chk(hlpt_pkg::ADDR_CTRL, 32'h0);
      wr(hlpt_pkg::ADDR_CTRL, 32'h80);
      watch(20, z, m);
      check(z, 20);
    end
    $display("edge one-shot done");
  endtask

  task t_res;
    int z;
    int m;
    for (int k = 0; k < 2; k++) begin
      setup(k[0] ? 5'h1f : 5'h10, 8'h3, 1'b0);
      wr(hlpt_pkg::ADDR_CTRL, 32'h80);
      lvl <= 1'b1;
      watch(40, z, m);
      check(z, 40);
      check(m, 0);
    end
    $display("reserved modes done");
  endtask

  initial begin
    reset_n_in      = 1'b0;
    address_in      = 5'h0;
    read_in         = 1'b0;
    write_in        = 1'b0;
    writedata_in    = 32'h0;
    debug_freeze_in = 1'b0;
    lvl             = 1'b0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_sw();
    t_post();
    t_gate();
    t_edge();
    t_level();
    t_os();
    t_eos();
    t_res();
    results();
  end
endmodule

// file: test/hlpt_trig_model.sv
// external trigger source model for the limit period timer
`timescale 1ns/1ps
module hlpt_trig_model (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic level_req_in,
  output logic      trig_out
);
  logic [3:0] hold;

  // a level change waits out the hold time, so trig_out holds each level for at least seven clocks
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      trig_out <= 1'b0;
      hold     <= 4'h0;
    end else if (level_req_in != trig_out && hold >= 4'h6) begin
      trig_out <= level_req_in;
      hold     <= 4'h0;
    end else if (hold != 4'hf) begin
      hold <= hold + 4'h1;
    end
  end
endmodule
